// ---- logic/output_sync_automute_ctrl.sv ----
// Output sync trigger and driver auto-unmute controller for one distribution channel
//
// Overview of operation
// - Drivers stay silent until a sync event; two-bit selector picks its source
// - Sync code 0: no automatic sync; software sync command makes the event
// - Sync code 1: sync event as soon as the analog loop locks
// - Sync code 2: sync event when the digital loop phase locks
// - Sync code 3: sync event when the digital loop frequency locks
// - One unmute mask bit per driver, bit 7 c-negative down to bit 2 a-positive
// - Mask bit 0: driver unmutes only when the selected unmute condition holds
// - Mask bit 1: unmute conditions ignored, driver unmuted at once
// - Two-bit unmute selector for hitless acquisition; selector and masks reset to 0
// - Unmute code 0: no automatic unmuting, drivers toggle immediately
// - Unmute code 1: unmute when a hitless profile becomes active
// - Unmute code 2: unmute on phase lock, only while in hitless mode
// - Unmute code 3: unmute on frequency lock, only while in hitless mode
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module output_sync_automute_ctrl
  import sync_unmute_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [ADDR_WIDTH-1:0]   address,
  input  wire logic [DATA_WIDTH-1:0]   writeData,
  input  wire logic                    writeStrobe,
  input  wire logic                    readStrobe,
  output logic      [DATA_WIDTH-1:0]   readData,
  input  wire logic                    analogLocked,
  input  wire logic                    phaseLocked,
  input  wire logic                    freqLocked,
  input  wire logic                    hitlessActive,
  input  wire logic                    hitlessMode,
  input  wire logic                    muteRequest,
  output logic                         syncEvent,
  output logic                         synced,
  output logic      [DRIVER_COUNT-1:0] driverToggle
);

  typedef struct packed {
    sync_mode_e              syncMode;
    logic                    refSyncEnable;
    unmute_mode_e            unmuteMode;
    logic [DRIVER_COUNT-1:0] unmuteMask;
    logic                    synced;
    logic [DRIVER_COUNT-1:0] unmuted;
    logic [DRIVER_COUNT-1:0] toggle;
    logic                    syncPulse;
    logic [DATA_WIDTH-1:0]   readData;
  } state_s;

  state_s state;
  state_s next_state;

  unmute_if link ();

  unmute_decider decider (
    .link (link.decider)
  );

  assign link.unmuteMode    = state.unmuteMode;
  assign link.unmuteMask    = state.unmuteMask;
  assign link.phaseLocked   = phaseLocked;
  assign link.freqLocked    = freqLocked;
  assign link.hitlessActive = hitlessActive;
  assign link.hitlessMode   = hitlessMode;

  function automatic logic regHit(input logic [ADDR_WIDTH-1:0] addr,
                                  input logic [ADDR_WIDTH-1:0] offset);
    return addr == offset;
  endfunction : regHit

  function automatic logic syncCondition(input sync_mode_e mode,
                                         input logic apll,
                                         input logic phase,
                                         input logic freq);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      SYNC_MANUAL:      hit = 1'b0;
      SYNC_ANALOG_LOCK: hit = apll;
      SYNC_PHASE_LOCK:  hit = phase;
      SYNC_FREQ_LOCK:   hit = freq;
    endcase
    return hit;
  endfunction : syncCondition

  logic writeSync;
  logic writeUnmute;
  logic writeCommand;
  logic syncCommand;
  logic remuteCommand;
  logic syncFire;
  logic clearSync;
  logic clearUnmute;
  logic [DATA_WIDTH-1:0] readValue;

  always_comb begin
    writeSync     = writeStrobe & regHit(address, SYNC_CONTROL_OFFSET);
    writeUnmute   = writeStrobe & regHit(address, UNMUTE_CONTROL_OFFSET);
    writeCommand  = writeStrobe & regHit(address, SYNC_COMMAND_OFFSET);
    syncCommand   = writeCommand & writeData[CMD_SYNC_BIT];
    remuteCommand = writeCommand & writeData[CMD_REMUTE_BIT];
    // Sync fires once per armed period; a level lock input does not retrigger
    syncFire = ~state.synced
             & (syncCommand
                | syncCondition(state.syncMode, analogLocked, phaseLocked, freqLocked));
    // Rewriting the selector counts as reconfiguration and rearms the sync
    clearSync   = muteRequest | remuteCommand | writeSync;
    clearUnmute = muteRequest | remuteCommand | writeUnmute;

    readValue = '0;
    if (regHit(address, SYNC_CONTROL_OFFSET)) begin
      readValue[SYNC_MODE_LSB +: 2] = state.syncMode;
      readValue[REF_SYNC_BIT]       = state.refSyncEnable;
    end else if (regHit(address, UNMUTE_CONTROL_OFFSET)) begin
      readValue[UNMUTE_MODE_LSB +: 2]            = state.unmuteMode;
      readValue[UNMUTE_MASK_LSB +: DRIVER_COUNT] = state.unmuteMask;
    end else if (regHit(address, SYNC_STATUS_OFFSET)) begin
      readValue[STATUS_SYNCED_BIT]                = state.synced;
      readValue[STATUS_DRIVER_LSB +: DRIVER_COUNT] = state.toggle;
    end

    next_state = state;
    next_state.syncPulse = syncFire;
    next_state.readData  = readStrobe ? readValue : '0;

    if (writeSync) begin
      next_state.syncMode      = sync_mode_e'(writeData[SYNC_MODE_LSB +: 2]);
      next_state.refSyncEnable = writeData[REF_SYNC_BIT];
    end
    if (writeUnmute) begin
      next_state.unmuteMode = unmute_mode_e'(writeData[UNMUTE_MODE_LSB +: 2]);
      next_state.unmuteMask = writeData[UNMUTE_MASK_LSB +: DRIVER_COUNT];
    end

    // Set wins over clear so a lock arriving with a mute is not lost
    if (clearSync) begin
      next_state.synced = 1'b0;
    end
    if (syncFire) begin
      next_state.synced = 1'b1;
    end

    for (int i = 0; i < DRIVER_COUNT; i++) begin
      if (clearUnmute) begin
        next_state.unmuted[i] = 1'b0;
      end
      if (link.unmuteGrant[i]) begin
        next_state.unmuted[i] = 1'b1;
      end
    end

    // Drivers toggle only after sync and their own unmute
    next_state.toggle = next_state.synced ? next_state.unmuted : '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state               <= '0;
      state.syncMode      <= sync_mode_e'(SYNC_MODE_RESET);
      state.refSyncEnable <= REF_SYNC_RESET;
      state.unmuteMode    <= unmute_mode_e'(UNMUTE_MODE_RESET);
      state.unmuteMask    <= UNMUTE_MASK_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign readData     = state.readData;
  assign syncEvent    = state.syncPulse;
  assign synced       = state.synced;
  assign driverToggle = state.toggle;

endmodule : output_sync_automute_ctrl
`default_nettype wire

// ---- logic/sync_unmute_pkg.sv ----
// Register map, field layout and mode encodings of the output sync and unmute control
package sync_unmute_pkg;

  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int DRIVER_COUNT = 6;

  localparam logic [ADDR_WIDTH-1:0] SYNC_CONTROL_OFFSET   = 16'h10DB;
  localparam logic [ADDR_WIDTH-1:0] UNMUTE_CONTROL_OFFSET = 16'h10DC;
  localparam logic [ADDR_WIDTH-1:0] SYNC_STATUS_OFFSET    = 16'h10DD;
  localparam logic [ADDR_WIDTH-1:0] SYNC_COMMAND_OFFSET   = 16'h10DE;

  localparam int SYNC_MODE_LSB = 0;
  localparam int REF_SYNC_BIT = 2;
  localparam int UNMUTE_MODE_LSB = 0;
  localparam int UNMUTE_MASK_LSB = 2;
  localparam int CMD_SYNC_BIT = 0;
  localparam int CMD_REMUTE_BIT = 1;
  localparam int STATUS_SYNCED_BIT = 0;
  localparam int STATUS_DRIVER_LSB = 2;

  localparam logic [1:0] SYNC_MODE_RESET = 2'h0;
  localparam logic REF_SYNC_RESET = 1'h0;
  localparam logic [1:0] UNMUTE_MODE_RESET = 2'h0;
  localparam logic [DRIVER_COUNT-1:0] UNMUTE_MASK_RESET = 6'h00;

  typedef enum logic [1:0] {
    SYNC_MANUAL,
    SYNC_ANALOG_LOCK,
    SYNC_PHASE_LOCK,
    SYNC_FREQ_LOCK
  } sync_mode_e;

  typedef enum logic [1:0] {
    UNMUTE_IMMEDIATE,
    UNMUTE_HITLESS_PROFILE,
    UNMUTE_PHASE_LOCK,
    UNMUTE_FREQ_LOCK
  } unmute_mode_e;

endpackage : sync_unmute_pkg

// ---- logic/unmute_decider.sv ----
// Per-driver unmute condition: selected automatic condition or mask bypass
`timescale 1ns/1ps
`default_nettype none
module unmute_decider
  import sync_unmute_pkg::*;
(
  unmute_if.decider link
);
  logic modeCondition;

  always_comb begin
    unique case (link.unmuteMode)
      UNMUTE_IMMEDIATE:       modeCondition = 1'b1;
      UNMUTE_HITLESS_PROFILE: modeCondition = link.hitlessActive;
      UNMUTE_PHASE_LOCK:      modeCondition = link.phaseLocked & link.hitlessMode;
      UNMUTE_FREQ_LOCK:       modeCondition = link.freqLocked & link.hitlessMode;
    endcase
  end

  // Mask set bypasses the condition entirely
  for (genvar i = 0; i < DRIVER_COUNT; i++) begin : g_driver
    assign link.unmuteGrant[i] = link.unmuteMask[i] | modeCondition;
  end
endmodule : unmute_decider
`default_nettype wire

// ---- logic/unmute_if.sv ----
// Link between the controller and its per-driver unmute decider
`timescale 1ns/1ps
`default_nettype none
interface unmute_if
  import sync_unmute_pkg::*;
;
  unmute_mode_e            unmuteMode;
  logic [DRIVER_COUNT-1:0] unmuteMask;
  logic                    phaseLocked;
  logic                    freqLocked;
  logic                    hitlessActive;
  logic                    hitlessMode;
  logic [DRIVER_COUNT-1:0] unmuteGrant;

  modport controller (
    output unmuteMode,
    output unmuteMask,
    output phaseLocked,
    output freqLocked,
    output hitlessActive,
    output hitlessMode,
    input  unmuteGrant
  );

  modport decider (
    input  unmuteMode,
    input  unmuteMask,
    input  phaseLocked,
    input  freqLocked,
    input  hitlessActive,
    input  hitlessMode,
    output unmuteGrant
  );
endinterface : unmute_if
`default_nettype wire

// ---- test/output_sync_automute_ctrl_props.sv ----
// Port checks on the output sync and unmute controller
`timescale 1ns/1ps
`default_nettype none
module output_sync_automute_ctrl_props
  import sync_unmute_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic [ADDR_WIDTH-1:0]   address,
  input wire logic [DATA_WIDTH-1:0]   writeData,
  input wire logic                    writeStrobe,
  input wire logic                    readStrobe,
  input wire logic [DATA_WIDTH-1:0]   readData,
  input wire logic                    analogLocked,
  input wire logic                    phaseLocked,
  input wire logic                    freqLocked,
  input wire logic                    hitlessActive,
  input wire logic                    hitlessMode,
  input wire logic                    muteRequest,
  input wire logic                    syncEvent,
  input wire logic                    synced,
  input wire logic [DRIVER_COUNT-1:0] driverToggle
);
  logic [1:0] sm, um;
  logic [5:0] mk;
  logic       quiet, grant;
  // Any write or mute request may reconfigure or rearm, so the lock, unmute and hold checks only look at cycles without one
  assign quiet = !writeStrobe && !muteRequest;
  assign grant = um == 2'h0 || (um == 2'h1 && hitlessActive) || (hitlessMode
    && ((um == 2'h2 && phaseLocked) || (um == 2'h3 && freqLocked)));
  always_ff @(posedge clock) begin
    if (rst) {sm, um, mk} <= 10'h000;
    else if (writeStrobe && address == SYNC_CONTROL_OFFSET) sm <= writeData[1:0];
    else if (writeStrobe && address == UNMUTE_CONTROL_OFFSET) {mk, um} <= writeData;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_quiet_unsynced: assert property (!synced |-> driverToggle == 6'h00)
    else $error("toggling before sync");
  a_manual_sync: assert property (!synced && writeStrobe && address == SYNC_COMMAND_OFFSET
    && writeData[CMD_SYNC_BIT] |=> syncEvent) else $error("no sync on command");
  a_analog_sync: assert property (quiet && !synced && sm == 2'h1 && analogLocked |=> syncEvent)
    else $error("no sync on analog lock");
  a_phase_sync: assert property (quiet && !synced && sm == 2'h2 && phaseLocked |=> syncEvent)
    else $error("no sync on phase lock");
  a_freq_sync: assert property (quiet && !synced && sm == 2'h3 && freqLocked |=> syncEvent)
    else $error("no sync on freq lock");
  a_mask_bypass: assert property (synced && quiet |=> (driverToggle & mk) == mk)
    else $error("masked driver muted");
  a_auto_unmute: assert property (synced && quiet && grant |=> driverToggle == 6'h3F)
    else $error("granted driver muted");
  a_toggle_holds: assert property (quiet |=>
    (driverToggle & $past(driverToggle)) == $past(driverToggle)) else $error("driver dropped");
endmodule : output_sync_automute_ctrl_props
bind output_sync_automute_ctrl output_sync_automute_ctrl_props props_u (.*);
`default_nettype wire

// ---- test/test_output_sync_automute_ctrl.sv ----
// Self-checking bench with a cycle model of the sync and unmute controller
`timescale 1ns/1ps
`default_nettype none
module test_output_sync_automute_ctrl
  import sync_unmute_pkg::*;
;
  logic                    clock, rst, writeStrobe, readStrobe, muteRequest, syncEvent, synced;
  logic                    analogLocked, phaseLocked, freqLocked, hitlessActive, hitlessMode;
  logic                    mS, mE;
  logic [ADDR_WIDTH-1:0]   address;
  logic [DATA_WIDTH-1:0]   writeData, readData, uc, eRd;
  logic [DRIVER_COUNT-1:0] driverToggle, mU, mT;
  logic [2:0]              sc;
  logic [31:0]             lfsr;
  int                      n_errors, cmp_count, cyc;
  localparam logic [15:0] PROBE [5] = '{SYNC_CONTROL_OFFSET, UNMUTE_CONTROL_OFFSET,
    SYNC_STATUS_OFFSET, SYNC_COMMAND_OFFSET, 16'h1234};

  output_sync_automute_ctrl dut_u (.*);

  function logic syncCond();
    return (sc[1:0] == 2'h1 && analogLocked) || (sc[1:0] == 2'h2 && phaseLocked)
      || (sc[1:0] == 2'h3 && freqLocked);
  endfunction : syncCond
  function logic grantAll();
    return uc[1:0] == 2'h0 || (uc[1:0] == 2'h1 && hitlessActive) || (hitlessMode
      && ((uc[1:0] == 2'h2 && phaseLocked) || (uc[1:0] == 2'h3 && freqLocked)));
  endfunction : grantAll
  function logic [7:0] expRead(input logic [15:0] a);
    case (a)
      SYNC_CONTROL_OFFSET:   return {5'h00, sc};
      UNMUTE_CONTROL_OFFSET: return uc;
      SYNC_STATUS_OFFSET:    return {mT, 1'b0, mS};
      default:               return 8'h00;
    endcase
  endfunction : expRead
  function logic [31:0] nextRand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nextRand

  // Cycle model: a write acts on the old setting in its own cycle, and a fire beats a clear
  always @(posedge clock) begin
    logic src, rem, clrS, clrU, nS;
    logic [5:0] nU;
    src = (writeStrobe && address == SYNC_COMMAND_OFFSET && writeData[0]) || syncCond();
    rem = muteRequest || (writeStrobe && address == SYNC_COMMAND_OFFSET && writeData[1]);
    clrS = rem || (writeStrobe && address == SYNC_CONTROL_OFFSET);
    clrU = rem || (writeStrobe && address == UNMUTE_CONTROL_OFFSET);
    nS = (mS && !clrS) || (!mS && src);
    nU = (clrU ? 6'h00 : mU) | uc[7:2] | {6{grantAll()}};
    if (rst) {mS, mE, mU, mT, sc, uc, eRd} <= 33'h000000000;
    else begin
      mE <= !mS && src;
      mS <= nS;
      mU <= nU;
      mT <= {6{nS}} & nU;
      eRd <= readStrobe ? expRead(address) : 8'h00;
      if (writeStrobe && address == SYNC_CONTROL_OFFSET) sc <= writeData[2:0];
      if (writeStrobe && address == UNMUTE_CONTROL_OFFSET) uc <= writeData;
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task drive(input logic w, input logic r, input logic m, input logic [15:0] a,
             input logic [7:0] d, input logic [4:0] lk);
    @(posedge clock);
    writeStrobe <= w;
    readStrobe <= r;
    muteRequest <= m;
    address <= a;
    writeData <= d;
    {analogLocked, phaseLocked, freqLocked, hitlessActive, hitlessMode} <= lk;
  endtask : drive
  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  always @(negedge clock) begin
    if (!rst) begin
      chk({7'h00, syncEvent}, {7'h00, mE});
      chk({7'h00, synced}, {7'h00, mS});
      chk({2'h0, driverToggle}, {2'h0, mT});
      chk(readData, eRd);
    end
  end
  // Whole run is about 1100 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_sim;
    end
  end

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {rst, writeStrobe, readStrobe, muteRequest, address, writeData} = 28'h8000000;
    {analogLocked, phaseLocked, freqLocked, hitlessActive, hitlessMode} = 5'h00;
    lfsr = 32'h00013969;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    drive(1'b1, 1'b0, 1'b0, 16'h1234, 8'hFF, 5'h00);
    for (int i = 0; i < 5; i++) drive(1'b0, 1'b1, 1'b0, PROBE[i], 8'h00, 5'h00);
    for (int cfg = 0; cfg < 16; cfg++) begin
      lfsr = nextRand(lfsr);
      drive(1'b1, 1'b0, 1'b0, SYNC_CONTROL_OFFSET, {5'h00, lfsr[2], cfg[3:2]}, 5'h00);
      drive(1'b1, 1'b0, 1'b0, UNMUTE_CONTROL_OFFSET, {lfsr[9:4], cfg[1:0]}, 5'h00);
      drive(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, 5'h00);
      for (int i = 0; i < 5; i++) drive(1'b0, 1'b1, 1'b0, PROBE[i], 8'h00, 5'h00);
      repeat (60) begin
        lfsr = nextRand(lfsr);
        drive(lfsr[7:4] == 4'h0, lfsr[7:4] == 4'h1, lfsr[11:8] == 4'h0,
              lfsr[12] ? SYNC_COMMAND_OFFSET : SYNC_STATUS_OFFSET, {6'h00, lfsr[14:13]},
              lfsr[20:16]);
      end
    end
    end_sim;
  end
endmodule : test_output_sync_automute_ctrl
`default_nettype wire
